// ==== design/blkirq_consts.svh ====
`ifndef BLKIRQ_CONSTS_SVH
`define BLKIRQ_CONSTS_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define BLKIRQ_ENABLE_ADDR 6'h20
`define BLKIRQ_STATUS_ADDR 6'h21
`define BLKIRQ_CH0_SRC_STATUS_ADDR 6'h02
`define BLKIRQ_CH1_SRC_STATUS_ADDR 6'h0A
`define BLKIRQ_CH2_SRC_STATUS_ADDR 6'h12
`define BLKIRQ_ENABLE_RESET 8'h00
`define BLKIRQ_STATUS_RESET 8'h00
`define BLKIRQ_CHAN_COUNT 3
`endif

// ==== design/blkirq_pkg.sv ====
package blkirq_pkg;
   typedef logic [7:0] blkirq_byte_t;
   typedef logic [5:0] blkirq_addr_t;
   typedef logic [2:0] blkirq_chan_t;
endpackage

// ==== design/blkirq_aggregator.sv ====
// Contract
// R1: enable bit 2 lets channel 2 sources interrupt; read/write, resets 0.
// R2: channel 2 enable low blocks every channel 2 interrupt.
// R3: source interrupts only when source enable and block enable both set.
// R4: enable bits 1 and 0 gate channels 1 and 0 likewise, reset 0.
// R5: status bit 2 reads 1 while a channel 2 interrupt is pending.
// R6: status bits 1 and 0 report channels 1 and 0, read-only, reset 0.
// R7: status bit stays set until host reads matching source status register.
// R8: host reads channel 2 source status at 0x12 on status bit 2.
// R9: host reads 0x0A or 0x02 for channels 1 or 0.
// R10: enable register sits at 0x20, bits 2..0 writable, upper bits zero.
// R11: irq output high when any status bit set; bits 7..3 read 0.
`timescale 1ns/10ps
`include "blkirq_consts.svh"
module blkirq_aggregator
(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   // register port
   input  wire logic                 regWrite,
   input  wire logic                 regRead,
   input  wire blkirq_pkg::blkirq_addr_t regAddr,
   input  wire blkirq_pkg::blkirq_byte_t regWdata,
   output      blkirq_pkg::blkirq_byte_t regRdata,
   // per channel source-level requests, already source-enable gated
   input  wire blkirq_pkg::blkirq_chan_t srcRequest,
   // interrupt out
   output      logic                 irqOut
);
   import blkirq_pkg::*;

   blkirq_chan_t enable_q;
   blkirq_chan_t status_q;
   blkirq_chan_t srcClear;
   blkirq_byte_t regRdata_q;
   logic         irq_q;

   // ----------------------------------------
   // source status read decode
   // ----------------------------------------
   // host service read of a source status register releases its block bit
   genvar sc;
   generate
      for (sc = 0; sc < `BLKIRQ_CHAN_COUNT; sc++)
      begin : gDecode
         localparam blkirq_addr_t SrcAddr = (sc == 2) ? `BLKIRQ_CH2_SRC_STATUS_ADDR :
                                            (sc == 1) ? `BLKIRQ_CH1_SRC_STATUS_ADDR :
                                                        `BLKIRQ_CH0_SRC_STATUS_ADDR;
         assign srcClear[sc] = regRead && (regAddr == SrcAddr); // [R8] [R9]
      end
   endgenerate

   // ----------------------------------------
   // block enable register
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         enable_q <= blkirq_chan_t'(`BLKIRQ_ENABLE_RESET); // [R1] [R4]
      else if (regWrite && regAddr == `BLKIRQ_ENABLE_ADDR)
         enable_q <= regWdata[2:0]; // [R10] [R11]
   end

   // ----------------------------------------
   // sticky block status, set wins over clear
   // ----------------------------------------
   genvar ch;
   generate
      for (ch = 0; ch < `BLKIRQ_CHAN_COUNT; ch++)
      begin : gChan
         always_ff @(posedge clk)
         begin
            if (!reset_n)
               status_q[ch] <= 1'b0; // [R6]
            else if (srcRequest[ch] && enable_q[ch])
               status_q[ch] <= 1'b1; // [R2] [R3] [R5]
            else if (srcClear[ch])
               status_q[ch] <= 1'b0; // [R7]
         end
      end
   endgenerate

   // ----------------------------------------
   // read data and interrupt output
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         regRdata_q <= `BLKIRQ_STATUS_RESET;
      else
      begin
         case (regAddr)
            `BLKIRQ_ENABLE_ADDR:
               regRdata_q <= {5'h00, enable_q}; // [R10]
            `BLKIRQ_STATUS_ADDR:
               regRdata_q <= {5'h00, status_q}; // [R5] [R11]
            default:
               regRdata_q <= 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         irq_q <= 1'b0;
      else
         irq_q <= |status_q; // [R11]
   end

   assign regRdata = regRdata_q;
   assign irqOut   = irq_q;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   gate_blocked_a: assert property (!enable_q[2] && !status_q[2] |=> !status_q[2]) // [R2]
      else $error("channel 2 status set while disabled");
   gate_and_a: assert property (srcRequest[0] && enable_q[0] |=> status_q[0]) // [R3]
      else $error("channel 0 request not latched");
   enable_write_a: assert property (regWrite && regAddr == 6'h20 |=> enable_q == $past(regWdata[2:0])) // [R1]
      else $error("enable write lost");
   enable_hold_a: assert property (!(regWrite && regAddr == 6'h20) |=> $stable(enable_q)) // [R4]
      else $error("enable changed without write");
   status_sticky_a: assert property (status_q[1] && !srcClear[1] |=> status_q[1]) // [R7]
      else $error("status bit 1 dropped without read");
   status_clear_a: assert property (status_q[2] && srcClear[2] && !srcRequest[2] |=> !status_q[2]) // [R7]
      else $error("status bit 2 not cleared on read");
   status_read_a: assert property (regAddr == 6'h21 |=> regRdata == {5'h00, $past(status_q)}) // [R5]
      else $error("status readback wrong");
   upper_zero_a: assert property (regRdata[7:3] == 5'h00) // [R11]
      else $error("upper bits nonzero");
   irq_follow_a: assert property (1'b1 |=> irqOut == |$past(status_q)) // [R11]
      else $error("irq does not follow status");
   enable_read_a: assert property (regAddr == 6'h20 |=> regRdata == {5'h00, $past(enable_q)}) // [R10]
      else $error("enable readback wrong");

   // ----------------------------------------
   // per channel checks
   // ----------------------------------------
   genvar k;
   generate
      for (k = 0; k < `BLKIRQ_CHAN_COUNT; k++)
      begin : gChk
         chan_mask_a: assert property (!enable_q[k] && !status_q[k] // [R2] [R4]
            |=> !status_q[k])
            else $error("status set while channel disabled");

         chan_set_a: assert property (srcRequest[k] && enable_q[k] // [R3]
            |=> status_q[k])
            else $error("enabled request not latched");

         chan_hold_a: assert property (status_q[k] && !srcClear[k] // [R7]
            |=> status_q[k])
            else $error("status dropped without source read");

         chan_clear_a: assert property (status_q[k] && srcClear[k] && !srcRequest[k] // [R7]
            |=> !status_q[k])
            else $error("status not cleared by source read");

         chan_rise_a: assert property (!status_q[k] ##1 status_q[k] // [R3]
            |-> $past(srcRequest[k] && enable_q[k]))
            else $error("status rose without enabled request");

         chan_bit_a: assert property (regAddr == 6'h21 // [R6]
            |=> regRdata[k] == $past(status_q[k]))
            else $error("status bit readback wrong");
      end
   endgenerate

   // ----------------------------------------
   // reset checks
   // ----------------------------------------
   reset_enable_a: assert property (disable iff (1'b0) !reset_n |=> enable_q == 3'h0) // [R1] [R4]
      else $error("enable not cleared by reset");

   reset_status_a: assert property (disable iff (1'b0) !reset_n |=> status_q == 3'h0) // [R6]
      else $error("status not cleared by reset");

   reset_read_a: assert property (disable iff (1'b0) !reset_n |=> regRdata == 8'h00) // [R6]
      else $error("read data not cleared by reset");

   reset_irq_a: assert property (disable iff (1'b0) !reset_n |=> !irqOut) // [R11]
      else $error("irq not cleared by reset");

   // ----------------------------------------
   // register and irq checks
   // ----------------------------------------
   status_nowrite_a: assert property (regWrite && regAddr == 6'h21 && (srcRequest & enable_q) == 3'h0 // [R6]
      |=> $stable(status_q))
      else $error("status changed by write");

   enable_other_a: assert property (regWrite && regAddr != 6'h20 // [R10]
      |=> $stable(enable_q))
      else $error("enable changed by other address");

   irq_set_a: assert property (status_q != 3'h0 // [R11]
      |=> irqOut)
      else $error("irq low with status pending");

   irq_clear_a: assert property (status_q == 3'h0 // [R11]
      |=> !irqOut)
      else $error("irq high with no status");

   // ----------------------------------------
   // covers
   // ----------------------------------------
   cov_irq_c: cover property (srcRequest[2] && enable_q[2] ##1 status_q[2] ##1 irqOut);
   cov_clear_c: cover property (status_q[0] ##1 srcClear[0] ##1 !status_q[0]);
   cov_blocked_c: cover property (srcRequest[1] && !enable_q[1]);
   cov_setwins_c: cover property (srcClear[0] && srcRequest[0] && enable_q[0] ##1 status_q[0]);
   cov_reset_c: cover property (disable iff (1'b0) status_q != 3'h0 ##1 !reset_n);
endmodule

// ==== tb/blkirq_host.sv ====
`timescale 1ns/10ps
`include "blkirq_consts.svh"
module blkirq_host
(
   // bus in
   input  wire logic                     clk,
   input  wire blkirq_pkg::blkirq_byte_t regRdata,
   // bus out
   output logic                          regWrite,
   output logic                          regRead,
   output blkirq_pkg::blkirq_addr_t      regAddr,
   output blkirq_pkg::blkirq_byte_t      regWdata
);
   import blkirq_pkg::*;
   initial
   begin
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = 6'h3F;
      regWdata = 8'h00;
   end
   task automatic wr(input blkirq_addr_t a, input blkirq_byte_t d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
      regWdata <= ~d;
   endtask
   task automatic rd(input blkirq_addr_t a, output blkirq_byte_t d);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1 d = regRdata;
   endtask
   // service: read the channel's source status
   task automatic service(input int ch, output blkirq_byte_t d);
      rd(ch == 2 ? `BLKIRQ_CH2_SRC_STATUS_ADDR : ch == 1 ? `BLKIRQ_CH1_SRC_STATUS_ADDR :
         `BLKIRQ_CH0_SRC_STATUS_ADDR, d);
   endtask
endmodule

// ==== tb/blkirq_aggregator_tb.sv ====
`timescale 1ns/10ps
`include "blkirq_consts.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module blkirq_aggregator_tb;
   import blkirq_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic regWrite, regRead, irqOut;
   blkirq_addr_t regAddr;
   blkirq_byte_t regWdata, regRdata, d;
   blkirq_chan_t srcRequest = 3'h0;
   int err_count = 0, checked = 0, cyc = 0;
   always #50 clk = ~clk;
   blkirq_host host (.clk(clk), .regRdata(regRdata), .regWrite(regWrite), .regRead(regRead),
      .regAddr(regAddr), .regWdata(regWdata));
   blkirq_aggregator dut (.clk(clk), .reset_n(reset_n), .regWrite(regWrite), .regRead(regRead),
      .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .srcRequest(srcRequest), .irqOut(irqOut));
   task automatic end_sim();
      $display("errors %0d checks %0d", err_count, checked);
      if (err_count == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin err_count++; end_sim(); end
   end
   task automatic t_gate();
      host.rd(`BLKIRQ_ENABLE_ADDR, d); `CHK(d, 8'h00)
      @(posedge clk) srcRequest <= 3'h7;
      repeat (2) @(posedge clk);
      srcRequest <= 3'h0;
      host.rd(`BLKIRQ_STATUS_ADDR, d); `CHK(d, 8'h00)
      `CHK(irqOut, 1'b0)
      host.wr(`BLKIRQ_ENABLE_ADDR, 8'hFF);
      host.wr(`BLKIRQ_STATUS_ADDR, 8'hFF);
      host.rd(`BLKIRQ_ENABLE_ADDR, d); `CHK(d, 8'h07)
      host.rd(`BLKIRQ_STATUS_ADDR, d); `CHK(d, 8'h00)
   endtask
   task automatic t_chan(input int ch);
      host.wr(`BLKIRQ_ENABLE_ADDR, 8'h01 << ch);
      @(posedge clk) srcRequest <= 3'h7;
      @(posedge clk) srcRequest <= 3'h0;
      repeat (4) @(posedge clk);
      host.rd(`BLKIRQ_STATUS_ADDR, d); `CHK(d, 8'h01 << ch)
      `CHK(irqOut, 1'b1)
      host.wr(`BLKIRQ_STATUS_ADDR, 8'h00);
      host.rd(`BLKIRQ_STATUS_ADDR, d); `CHK(d, 8'h01 << ch)
      host.service(ch, d);
      host.rd(`BLKIRQ_STATUS_ADDR, d); `CHK(d, 8'h00)
      `CHK(irqOut, 1'b0)
   endtask
   task automatic t_reset();
      host.wr(`BLKIRQ_ENABLE_ADDR, 8'h07);
      @(posedge clk) srcRequest <= 3'h5;
      @(posedge clk) srcRequest <= 3'h1;
      host.service(0, d);
      @(posedge clk) srcRequest <= 3'h0;
      host.rd(`BLKIRQ_STATUS_ADDR, d); `CHK(d, 8'h05)
      `CHK(irqOut, 1'b1)
      @(posedge clk) reset_n <= 1'b0;
      @(posedge clk) reset_n <= 1'b1;
      host.rd(`BLKIRQ_ENABLE_ADDR, d); `CHK(d, 8'h00)
      host.rd(`BLKIRQ_STATUS_ADDR, d); `CHK(d, 8'h00)
      `CHK(irqOut, 1'b0)
   endtask
   initial
   begin
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      t_gate();
      for (int c = 0; c < 3; c++) t_chan(c);
      t_reset();
      end_sim();
   end
endmodule
